// ---- verilog/pma_array.sv ----
/*
 Top of the programmable macrocell array: the global bus, the AND array of
 every product term, the dedicated inputs, the macrocells and the I/O
 control block with tri-state pins and dual feedback.
 Assumes pins are synchronous to clk_sys and the configuration is static
 while running; the bench resolves each pad wire from io_pin_out and
 io_pin_oe.
*/
// Operation
// - Each macrocell has five terms; the fifth sets output polarity via XOR, or is the K or R input of a JK or SR register.
// - Each selectable term goes to OR, clock, clear, preset, enable or expander.
// - Any control can be tied to constant one or zero.
// - Register acts as D, T, JK or SR on its clock's rising edge.
// - Register can be bypassed so the logic drives the output directly.
// - Clock, clear and preset each come from a term or their global.
// - Four dedicated inputs are plain inputs or the four global controls.
// - Thirty-two pins each set as input, output or bidirectional.
// - Half the macrocells reach pins; the other half are buried.
// - Pin macrocells drive through tri-state, released when enable is off in bidirectional mode.
// - Both the macrocell signal and the pin value feed the bus.
// - Pin enable comes from global active-low enable or a term.
// - Up to 256 inverted-term expanders return onto the global bus.
// - Expanders see every bus signal and serve every product term.
// - Spare expanders cross-couple into flip-flops, latches or input registers.
// - All macrocells take their inputs from one shared global bus.
`timescale 1ns/1ps
module pma_array
#(
	parameter int NUM_MC = pma_pkg::NUM_MC,
	parameter int NUM_IO = pma_pkg::NUM_IO
)
(
	input  wire logic                    clk_sys,
	input  wire logic                    rst_n,
	input  wire logic [3:0]              ded_pin_in,
	input  wire logic [NUM_IO-1:0]       io_pin_in,
	output logic      [NUM_IO-1:0]       io_pin_out,
	output logic      [NUM_IO-1:0]       io_pin_oe,
	input  wire logic [3:0]              cfg_ded_global,
	input  wire logic [2*NUM_IO-1:0]     cfg_pin_mode,
	input  wire logic [NUM_MC*5*(4+NUM_IO+5*NUM_MC)-1:0] cfg_true_mask,
	input  wire logic [NUM_MC*5*(4+NUM_IO+5*NUM_MC)-1:0] cfg_comp_mask,
	input  wire logic [12*NUM_MC-1:0]    cfg_route,
	input  wire logic [2*NUM_MC-1:0]     cfg_clk_src,
	input  wire logic [2*NUM_MC-1:0]     cfg_clr_src,
	input  wire logic [2*NUM_MC-1:0]     cfg_pre_src,
	input  wire logic [2*NUM_MC-1:0]     cfg_oe_src,
	input  wire logic [2*NUM_MC-1:0]     cfg_ff_type,
	input  wire logic [NUM_MC-1:0]       cfg_bypass,
	output logic      [NUM_MC-1:0]       mc_state
);

	// Layout of the global bus: dedicated, pins, macrocells, expanders.
	localparam int BUS_DED = 0;
	localparam int BUS_PIN = BUS_DED + pma_pkg::NUM_DED;
	localparam int BUS_MC  = BUS_PIN + NUM_IO;
	localparam int BUS_EXP = BUS_MC + NUM_MC;
	localparam int NUM_EXP = pma_pkg::SEL_TERMS * NUM_MC;
	localparam int BUS_W   = BUS_EXP + NUM_EXP;
	localparam int NT      = pma_pkg::TERMS_PER_MC;

	// The pin cells are the lower half; the rest are buried, so refuse any other split.
	if (NUM_MC != 2 * NUM_IO)
	begin : g_bad_half
		$error("Half of the macrocells must own pins.");
	end
	if (NUM_IO < 1)
	begin : g_no_pins
		$error("At least one pin is needed.");
	end

	typedef struct packed
	{
		logic [3:0]        ded;
		logic [BUS_W-1:0]  bus;
		logic [NUM_IO-1:0] pin_o;
		logic [NUM_IO-1:0] pin_oe;
	} pma_top_state_t;

	pma_top_state_t s_r;
	pma_top_state_t s_nxt;

	logic [NUM_MC*NT-1:0]  term;
	logic [NUM_MC-1:0]     mc_out;
	logic [NUM_MC-1:0]     mc_oe;
	logic [NUM_EXP-1:0]    exp_out;
	logic                  g_clk;
	logic                  g_clr_low;
	logic                  g_pre_low;
	logic                  g_oe_low;

	// Dedicated inputs become globals only when configured so.
	always_comb
	begin
		g_clk = cfg_ded_global[pma_pkg::DED_CLK] & s_r.ded[pma_pkg::DED_CLK];
		g_clr_low = ~cfg_ded_global[pma_pkg::DED_CLR] | s_r.ded[pma_pkg::DED_CLR];
		g_pre_low = ~cfg_ded_global[pma_pkg::DED_PRE] | s_r.ded[pma_pkg::DED_PRE];
		g_oe_low = ~cfg_ded_global[pma_pkg::DED_OE] | s_r.ded[pma_pkg::DED_OE];
	end

	// Per macrocell: its product terms and the macrocell itself.
	for (genvar m = 0; m < NUM_MC; m++)
	begin : g_mc
		for (genvar t = 0; t < NT; t++)
		begin : g_term
			localparam int K = m * NT + t;
			logic [BUS_W-1:0] tm;
			logic [BUS_W-1:0] cm;
			assign tm = cfg_true_mask[K*BUS_W +: BUS_W];
			assign cm = cfg_comp_mask[K*BUS_W +: BUS_W];
			// Every term sees the whole registered bus, expanders included.
			assign term[K] = &((s_r.bus | ~tm) & (~s_r.bus | ~cm));
		end

		pma_macrocell u_mc
		(
			.clk_sys                  (clk_sys),
			.rst_n                    (rst_n),
			.term                     (term[m*NT +: NT]),
			.route                    (cfg_route[12*m +: 12]),
			.clk_src                  (cfg_clk_src[2*m +: 2]),
			.clr_src                  (cfg_clr_src[2*m +: 2]),
			.pre_src                  (cfg_pre_src[2*m +: 2]),
			.oe_src                   (cfg_oe_src[2*m +: 2]),
			.ff_type                  (cfg_ff_type[2*m +: 2]),
			.bypass                   (cfg_bypass[m]),
			.global_clock_pin         (g_clk),
			.global_clear_low         (g_clr_low),
			.global_preset_low        (g_pre_low),
			.global_output_enable_low (g_oe_low),
			.mc_out                   (mc_out[m]),
			.oe_out                   (mc_oe[m]),
			.exp_out                  (exp_out[4*m +: 4])
		);
	end

	logic [1:0] mode;
	logic       drive;

	// Next bus snapshot and the pin drivers of the I/O control block.
	always_comb
	begin
		s_nxt = s_r;
		mode = pma_pkg::PIN_OFF;
		drive = 1'h0;
		s_nxt.ded = ded_pin_in;
		// A dedicated pin used as a global reads as zero on the bus.
		s_nxt.bus[BUS_DED +: 4] = ded_pin_in & ~cfg_ded_global;
		s_nxt.bus[BUS_MC +: NUM_MC] = mc_out;
		// Expanders are inverted terms looped back one cycle later.
		s_nxt.bus[BUS_EXP +: NUM_EXP] = exp_out;
		for (int i = 0; i < NUM_IO; i++)
		begin
			mode = cfg_pin_mode[2*i +: 2];
			case (mode)
				pma_pkg::PIN_OUT:   drive = 1'h1;
				pma_pkg::PIN_BIDIR: drive = mc_oe[i];
				default:            drive = 1'h0;
			endcase
			s_nxt.pin_o[i] = mc_out[i];
			s_nxt.pin_oe[i] = drive;
			// Pad value after the buffer: own drive, else the outside level.
			s_nxt.bus[BUS_PIN + i] = s_r.pin_oe[i] ? s_r.pin_o[i] : io_pin_in[i];
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Outputs straight from the state register.
	assign io_pin_out = s_r.pin_o;
	assign io_pin_oe = s_r.pin_oe;
	assign mc_state = s_r.bus[BUS_MC +: NUM_MC];

endmodule

// ---- shared/pma_pkg.sv ----
/*
 Constants of the macrocell array: sizes, dedicated input roles, select-matrix
 route codes, control source codes, register types and pin modes.
 Assumes nothing of its surroundings; both design files use it by scope.
*/
package pma_pkg;

	// Default sizes of the array.
	localparam int NUM_MC       = 64;
	localparam int NUM_IO       = 32;
	localparam int NUM_DED      = 4;
	localparam int TERMS_PER_MC = 5;
	localparam int SEL_TERMS    = 4;
	localparam int XOR_TERM     = 4;

	// Role of each dedicated input when used as a global.
	localparam int DED_CLK = 0;
	localparam int DED_CLR = 1;
	localparam int DED_PRE = 2;
	localparam int DED_OE  = 3;

	// Destination of one select-matrix product term.
	localparam logic [2:0] ROUTE_OR  = 3'h0;
	localparam logic [2:0] ROUTE_CLK = 3'h1;
	localparam logic [2:0] ROUTE_CLR = 3'h2;
	localparam logic [2:0] ROUTE_PRE = 3'h3;
	localparam logic [2:0] ROUTE_OE  = 3'h4;
	localparam logic [2:0] ROUTE_EXP = 3'h5;
	localparam logic [2:0] ROUTE_OFF = 3'h6;

	// Source of a register or output-enable control.
	localparam logic [1:0] SRC_GLOBAL = 2'h0;
	localparam logic [1:0] SRC_TERM   = 2'h1;
	localparam logic [1:0] SRC_ONE    = 2'h2;
	localparam logic [1:0] SRC_ZERO   = 2'h3;

	// Register behaviour of a macrocell.
	localparam logic [1:0] FF_D  = 2'h0;
	localparam logic [1:0] FF_T  = 2'h1;
	localparam logic [1:0] FF_JK = 2'h2;
	localparam logic [1:0] FF_SR = 2'h3;

	// Direction of an I/O pin.
	localparam logic [1:0] PIN_IN    = 2'h0;
	localparam logic [1:0] PIN_OUT   = 2'h1;
	localparam logic [1:0] PIN_BIDIR = 2'h2;
	localparam logic [1:0] PIN_OFF   = 2'h3;

	// Register value after reset, and cycles an expander adds on the bus.
	localparam logic Q_RESET                     = 1'h0;
	localparam int   SHARED_EXPANDER_DELAY_CYC   = 1;

endpackage

// ---- verilog/pma_macrocell.sv ----
/*
 One macrocell: product-term select matrix, XOR polarity gate, the
 configurable register with its clock, clear and preset selection, and the
 output-enable selection. Product terms arrive already formed by the array.
 Assumes its inputs are synchronous to clk_sys and come from registered state.
*/
`timescale 1ns/1ps
module pma_macrocell
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [4:0] term,
	input  wire logic [11:0] route,
	input  wire logic [1:0] clk_src,
	input  wire logic [1:0] clr_src,
	input  wire logic [1:0] pre_src,
	input  wire logic [1:0] oe_src,
	input  wire logic [1:0] ff_type,
	input  wire logic       bypass,
	input  wire logic       global_clock_pin,
	input  wire logic       global_clear_low,
	input  wire logic       global_preset_low,
	input  wire logic       global_output_enable_low,
	output logic            mc_out,
	output logic            oe_out,
	output logic [3:0]      exp_out
);

	typedef struct packed
	{
		logic q;
		logic clk_prev;
	} pma_mc_state_t;

	pma_mc_state_t s_r;
	pma_mc_state_t s_nxt;

	// Picks a control from its global, its term or a constant level.
	function automatic logic pick(input logic [1:0] src, input logic g, input logic t);
		logic v;
		v = 1'h0;
		case (src)
			pma_pkg::SRC_GLOBAL: v = g;
			pma_pkg::SRC_TERM:   v = t;
			pma_pkg::SRC_ONE:    v = 1'h1;
			default:             v = 1'h0;
		endcase
		return v;
	endfunction

	logic or_sum;
	logic clk_t;
	logic clr_t;
	logic pre_t;
	logic oe_t;
	logic func;
	logic clk_sel;
	logic clr;
	logic pre;

	// Select matrix, polarity gate and register next state.
	always_comb
	begin
		s_nxt = s_r;
		or_sum = 1'h0;
		clk_t = 1'h0;
		clr_t = 1'h0;
		pre_t = 1'h0;
		oe_t = 1'h0;
		exp_out = 4'hf;
		for (int i = 0; i < pma_pkg::SEL_TERMS; i++)
		begin
			case (route[3*i +: 3])
				pma_pkg::ROUTE_OR:  or_sum = or_sum | term[i];
				pma_pkg::ROUTE_CLK: clk_t = clk_t | term[i];
				pma_pkg::ROUTE_CLR: clr_t = clr_t | term[i];
				pma_pkg::ROUTE_PRE: pre_t = pre_t | term[i];
				pma_pkg::ROUTE_OE:  oe_t = oe_t | term[i];
				pma_pkg::ROUTE_EXP: exp_out[i] = ~term[i];
				default:            ;
			endcase
		end
		func = or_sum ^ term[pma_pkg::XOR_TERM];
		clk_sel = pick(clk_src, global_clock_pin, clk_t);
		clr = pick(clr_src, ~global_clear_low, clr_t);
		pre = pick(pre_src, ~global_preset_low, pre_t);
		oe_out = pick(oe_src, ~global_output_enable_low, oe_t);
		s_nxt.clk_prev = clk_sel;
		if (clk_sel && !s_r.clk_prev)
		begin
			case (ff_type)
				pma_pkg::FF_D:  s_nxt.q = func;
				pma_pkg::FF_T:  s_nxt.q = s_r.q ^ func;
				pma_pkg::FF_JK: s_nxt.q = (or_sum & ~s_r.q) | (~term[pma_pkg::XOR_TERM] & s_r.q);
				default:        s_nxt.q = or_sum ? 1'h1 : (term[pma_pkg::XOR_TERM] ? 1'h0 : s_r.q);
			endcase
		end
		if (clr)
			s_nxt.q = 1'h0;
		else if (pre)
			s_nxt.q = 1'h1;
		mc_out = bypass ? func : s_r.q;
	end

	// State register.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '{q: pma_pkg::Q_RESET, clk_prev: 1'h0};
		else
			s_r <= s_nxt;
	end

endmodule

// ---- sim/pma_array_chk.sv ----
/*
 Checker of pin enables and register controls of the array.
 Assumes pin i is fed by macrocell i; bound to pma_array below.
*/
`timescale 1ns/1ps
module pma_array_chk
#(
	parameter int NUM_MC = 4,
	parameter int NUM_IO = 2
)
(
	input wire logic                clk_sys,
	input wire logic                rst_n,
	input wire logic [3:0]          ded_pin_in,
	input wire logic [NUM_IO-1:0]   io_pin_oe,
	input wire logic [3:0]          cfg_ded_global,
	input wire logic [2*NUM_IO-1:0] cfg_pin_mode,
	input wire logic [2*NUM_MC-1:0] cfg_clk_src,
	input wire logic [2*NUM_MC-1:0] cfg_clr_src,
	input wire logic [2*NUM_MC-1:0] cfg_pre_src,
	input wire logic [2*NUM_MC-1:0] cfg_oe_src,
	input wire logic [NUM_MC-1:0]   cfg_bypass,
	input wire logic [NUM_MC-1:0]   mc_state
);
	// All checks share one clock and reset.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Pin enable follows the pin mode and the enable source.
	for (genvar i = 0; i < NUM_IO; i++)
	begin : g_pin
		wire logic [1:0] md = cfg_pin_mode[2*i+:2];
		wire logic [1:0] os = cfg_oe_src[2*i+:2];
		wire logic       bd = md == pma_pkg::PIN_BIDIR;
		a_quiet_pin: assert property ((md == pma_pkg::PIN_IN || md == pma_pkg::PIN_OFF)[*2] |-> !io_pin_oe[i])
			else $error("input pin driven");
		a_output_drives: assert property ((md == pma_pkg::PIN_OUT)[*3] |-> io_pin_oe[i])
			else $error("output pin released");
		a_const_enable: assert property ((bd && os == pma_pkg::SRC_ONE)[*3] |-> io_pin_oe[i])
			else $error("tied enable not driving");
		a_const_disable: assert property ((bd && os == pma_pkg::SRC_ZERO)[*3] |-> !io_pin_oe[i])
			else $error("tied-off enable driving");
		a_global_enable: assert property ((bd && os == 2'h0 && cfg_ded_global[3] && !ded_pin_in[3])[*4] |-> io_pin_oe[i])
			else $error("global enable ignored");
	end
	// Register controls from the dedicated pins, and idle registers.
	for (genvar m = 0; m < NUM_MC; m++)
	begin : g_mc
		wire logic glc = cfg_clr_src[2*m+:2] == pma_pkg::SRC_GLOBAL && cfg_ded_global[1] && !cfg_bypass[m];
		wire logic glp = cfg_pre_src[2*m+:2] == pma_pkg::SRC_GLOBAL && cfg_ded_global[2] && glc;
		wire logic frz = cfg_clk_src[2*m+:2] == pma_pkg::SRC_ZERO && cfg_clr_src[2*m+:2] == pma_pkg::SRC_ZERO
			&& cfg_pre_src[2*m+:2] == pma_pkg::SRC_ZERO && !cfg_bypass[m];
		sequence s_clear_held;
			(glc && !ded_pin_in[1])[*5];
		endsequence
		sequence s_preset_held;
			(glp && ded_pin_in[1] && !ded_pin_in[2])[*5];
		endsequence
		a_clear_zeroes: assert property (s_clear_held |-> !mc_state[m])
			else $error("clear did not zero");
		a_preset_sets: assert property (s_preset_held |-> mc_state[m])
			else $error("preset did not set");
		a_idle_holds: assert property (frz |-> $stable(mc_state[m]))
			else $error("unclocked register changed");
	end
endmodule
bind pma_array pma_array_chk #(.NUM_MC(NUM_MC), .NUM_IO(NUM_IO)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.ded_pin_in(ded_pin_in), .io_pin_oe(io_pin_oe), .cfg_ded_global(cfg_ded_global), .cfg_pin_mode(cfg_pin_mode),
	.cfg_clk_src(cfg_clk_src), .cfg_clr_src(cfg_clr_src), .cfg_pre_src(cfg_pre_src), .cfg_oe_src(cfg_oe_src),
	.cfg_bypass(cfg_bypass), .mc_state(mc_state));

// ---- sim/pma_board.sv ----
/*
 Board around the array: resolves each pad.
 Assumes one external driver shared by all pins and a pull-up on each pad.
*/
`timescale 1ns/1ps
module pma_board
#(
	parameter int NUM_IO = 2
)
(
	input wire logic [NUM_IO-1:0] io_pin_out,
	input wire logic [NUM_IO-1:0] io_pin_oe,
	input wire logic              ext_val,
	input wire logic              ext_en,
	output logic     [NUM_IO-1:0] io_pin_in
);
	// Device drive wins, then the board driver, then the pull-up.
	always_comb
	begin
		for (int i = 0; i < NUM_IO; i++)
			io_pin_in[i] = io_pin_oe[i] ? io_pin_out[i] : (ext_en ? ext_val : 1'b1);
	end
endmodule

// ---- sim/programmable_macrocell_array_test.sv ----
/*
 Bench of the array with four macrocells and two pins.
 Assumes the board model resolves the pads.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("mismatch %0t got %b", $time, a); end end
module programmable_macrocell_array_test;
	localparam int NM = 4;
	localparam int BW = 26;
	logic              clk_sys = 1'b0;
	logic              rst_n = 1'b0;
	logic [3:0]        ded = 4'he;
	logic [1:0]        pin_in, pin_out, pin_oe;
	logic [3:0]        dglob = 4'hf;
	logic [3:0]        pmode;
	logic [NM*5*BW-1:0] tm, cm;
	logic [12*NM-1:0]  rt;
	logic [2*NM-1:0]   cks, crs, prs, oes, fft;
	logic [NM-1:0]     byp, st;
	logic              ext_val = 1'b0;
	int                n_fail = 0;
	int                comparisons = 0;
	// Clock of 20 ns.
	always #10 clk_sys = ~clk_sys;
	pma_board board (.io_pin_out(pin_out), .io_pin_oe(pin_oe), .ext_val(ext_val), .ext_en(1'b1), .io_pin_in(pin_in));
	pma_array #(.NUM_MC(NM), .NUM_IO(2)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ded_pin_in(ded),
		.io_pin_in(pin_in), .io_pin_out(pin_out), .io_pin_oe(pin_oe), .cfg_ded_global(dglob), .cfg_pin_mode(pmode),
		.cfg_true_mask(tm), .cfg_comp_mask(cm), .cfg_route(rt), .cfg_clk_src(cks), .cfg_clr_src(crs),
		.cfg_pre_src(prs), .cfg_oe_src(oes), .cfg_ff_type(fft), .cfg_bypass(byp), .mc_state(st));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Global clock pulse, two cycles high and two low.
	task automatic pulse_clock;
		ded[0] = 1'b1;
		tick(2);
		ded[0] = 1'b0;
		tick(2);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Cuts a hang short.
	initial
	begin
		#20us;
		n_fail++;
		print_verdict();
	end
	// Cell 0 is pin 1 through a bypass, cell 2 a buried register on pin 1.
	initial
	begin
		tm = '0;
		cm = '0;
		tm[5] = 1'b1;
		tm[10*BW+5] = 1'b1;
		tm[14*BW] = 1'b1;
		cm[14*BW] = 1'b1;
		rt = {4*NM{pma_pkg::ROUTE_OFF}};
		rt[2:0] = pma_pkg::ROUTE_OR;
		rt[26:24] = pma_pkg::ROUTE_OR;
		{cks, crs, prs} = {3*NM{pma_pkg::SRC_ZERO}};
		{cks[5:4], crs[5:4], prs[5:4]} = 6'h0;
		oes = {NM{pma_pkg::SRC_GLOBAL}};
		fft = {NM{pma_pkg::FF_D}};
		byp = 4'h1;
		pmode = {pma_pkg::PIN_IN, pma_pkg::PIN_OUT};
		tick(3);
		rst_n = 1'b1;
		for (int p = 0; p < 2; p++)
			for (int v = 0; v < 2; v++)
			begin
				{tm[4*BW], cm[4*BW]} = {2{~p[0]}};
				ext_val = v[0];
				tick(4);
				`CHK(pin_out[0], v[0] ^ p[0])
				`CHK(st[0], v[0] ^ p[0])
			end
		$display("polarity test ended");
		for (int f = 0; f < 4; f++)
		begin
			fft[5:4] = f[1:0];
			ext_val = 1'b1;
			ded[1] = 1'b0;
			tick(5);
			`CHK(st[2], 1'b0)
			ded[1] = 1'b1;
			tick(1);
			pulse_clock();
			`CHK(st[2], 1'b1)
			pulse_clock();
			`CHK(st[2], f[1:0] !== pma_pkg::FF_T)
		end
		fft[5:4] = pma_pkg::FF_D;
		ext_val = 1'b0;
		pulse_clock();
		`CHK(st[2], 1'b0)
		ded[2] = 1'b0;
		tick(5);
		`CHK(st[2], 1'b1)
		ded[1] = 1'b0;
		tick(5);
		`CHK(st[2], 1'b0)
		ded = 4'he;
		$display("register test ended");
		for (int md = 0; md < 4; md++)
		begin
			pmode[1:0] = md[1:0];
			tick(3);
			`CHK(pin_oe[0], md == 1)
		end
		rt[5:3] = pma_pkg::ROUTE_OE;
		pmode[1:0] = pma_pkg::PIN_BIDIR;
		for (int s = 0; s < 5; s++)
		begin
			oes[1:0] = s[1:0];
			ded[3] = s[2];
			tick(4);
			`CHK(pin_oe[0], s < 3)
		end
		$display("enable test ended");
		// Cell 1 reads dedicated pin 0 while its own pin is an input, and buried cell 3 sees it inverted.
		tm[5*BW] = 1'b1;
		{tm[9*BW], cm[9*BW], tm[19*BW], cm[19*BW]} = 4'hf;
		tm[15*BW+7] = 1'b1;
		tm[16*BW+22] = 1'b1;
		rt[14:12] = pma_pkg::ROUTE_OR;
		rt[38:36] = pma_pkg::ROUTE_EXP;
		rt[41:39] = pma_pkg::ROUTE_OR;
		byp[3:1] = 3'h5;
		for (int g = 0; g < 2; g++)
			for (int d = 0; d < 2; d++)
			begin
				dglob[0] = g[0];
				ded[0] = d[0];
				tick(5);
				`CHK(st[1], d[0] & ~g[0])
				`CHK(pin_out[1], d[0] & ~g[0])
				`CHK(pin_oe[1], 1'b0)
				`CHK(st[3], ~(d[0] & ~g[0]))
			end
		$display("expander test ended");
		print_verdict();
	end
endmodule
